// ===== fspw_pkg.sv
// shared constants and types for the first-stage page walker
package fspw_pkg;
   localparam int ADDR_W      = 64;
   localparam int PASID_W     = 20;
   localparam int FRAME_W     = 40;
   localparam int HAW_W       = 6;
   localparam int LVL_W       = 3;
   localparam int PAGE_SHIFT  = 12;
   localparam int IDX_BITS    = 9;
   localparam int ENTRY_SHIFT = 3;
   localparam int CANON4_N    = 48;
   localparam int CANON5_N    = 57;
   localparam int PA_TOP      = 51;
   localparam int PRESENT_BIT = 0;
   localparam int PS_BIT      = 7;
   localparam int EA_BIT      = 10;
   localparam int XD_BIT      = 63;
   localparam int LARGE_RSV_LO = 13;
   localparam int GIANT_RSV_HI = 29;
   localparam int LARGE_RSV_HI = 20;
   localparam logic [LVL_W-1:0] LVL_ROOT5 = 3'h5;
   localparam logic [LVL_W-1:0] LVL_ROOT4 = 3'h4;
   localparam logic [LVL_W-1:0] LVL_GIANT = 3'h3;
   localparam logic [LVL_W-1:0] LVL_LARGE = 3'h2;
   localparam logic [LVL_W-1:0] LVL_LEAF  = 3'h1;
   localparam logic [LVL_W-1:0] LVL_NONE  = 3'h0;
   localparam logic GIANT_PAGE_SUPPORT = 1'h1;
   localparam logic FIVE_LEVEL_SUPPORT = 1'h1;
   typedef enum logic [1:0] {
      PAGE_4K,
      PAGE_2M,
      PAGE_1G
   } fspw_page_t;
endpackage

// ===== fspw_check_if.sv
// entry under test and its verdict, between walker and checker
`timescale 1ns/1ps
interface fspw_check_if;
   logic [fspw_pkg::ADDR_W-1:0] entry;
   logic [fspw_pkg::LVL_W-1:0]  level;
   logic [fspw_pkg::HAW_W-1:0]  host_addr_width;
   logic                        noExec;
   logic                        giantOk;
   logic                        fault;
   logic                        leaf;
   modport walker  (output entry, level, host_addr_width, noExec, giantOk, input fault, leaf);
   modport judge   (input entry, level, host_addr_width, noExec, giantOk, output fault, leaf);
endinterface

// ===== fspw_entry_check.sv
// combinational present and reserved-bit check of one paging entry
`timescale 1ns/1ps
module fspw_entry_check (
   // entry and verdict
   fspw_check_if.judge chk
);
   function automatic logic [fspw_pkg::ADDR_W-1:0] hawMask(input logic [fspw_pkg::HAW_W-1:0] host_addr_width);
      logic [fspw_pkg::ADDR_W-1:0] m;
      m = '0;
      for (int i = 0; i < fspw_pkg::ADDR_W; i++) begin
         m[i] = (i >= int'(host_addr_width)) && (i <= fspw_pkg::PA_TOP);
      end
      return m;
   endfunction

   wire present  = chk.entry[fspw_pkg::PRESENT_BIT];
   wire psSet    = chk.entry[fspw_pkg::PS_BIT];
   wire isGiant  = chk.level == fspw_pkg::LVL_GIANT;
   wire isLarge  = chk.level == fspw_pkg::LVL_LARGE;
   wire rsvHaw   = |(chk.entry & hawMask(chk.host_addr_width));
   wire rsvPs    = psSet && ((chk.level >= fspw_pkg::LVL_ROOT4) || (isGiant && !chk.giantOk));
   wire bigPage  = psSet && ((isGiant && chk.giantOk) || isLarge);
   // low frame bits of large pages
   wire rsvGiant = bigPage && isGiant && (|chk.entry[fspw_pkg::GIANT_RSV_HI:fspw_pkg::LARGE_RSV_LO]);
   wire rsvLarge = bigPage && isLarge && (|chk.entry[fspw_pkg::LARGE_RSV_HI:fspw_pkg::LARGE_RSV_LO]);
   wire rsvXd    = !chk.noExec && chk.entry[fspw_pkg::XD_BIT];
   // extended-accessed bit is never examined here

   assign chk.fault = !present || rsvHaw || rsvPs || rsvGiant || rsvLarge || rsvXd;
   assign chk.leaf  = present && ((chk.level == fspw_pkg::LVL_LEAF) || bigPage);
endmodule

// ===== first_stage_page_walker.sv
// first-stage translation walker: canonical check, table walk, result
`timescale 1ns/1ps
module first_stage_page_walker (
   // clock and reset
   input  logic                         clock,
   input  logic                         reset,
   // translation request
   input  logic                         reqValid,
   output logic                         reqReady,
   input  logic [fspw_pkg::ADDR_W-1:0]  reqAddr,
   input  logic                         reqHasPasid,
   input  logic [fspw_pkg::PASID_W-1:0] reqPasid,
   // context and PASID-table settings
   input  logic [fspw_pkg::PASID_W-1:0] defaultRequestPasid,
   input  logic                         stageOnePagingMode,
   input  logic [fspw_pkg::FRAME_W-1:0] stageOneTablePointer,
   input  logic                         noExecEnable,
   input  logic [fspw_pkg::HAW_W-1:0]   hostAddrWidth,
   // capability
   output logic                         giantPageSupport,
   // paging-structure memory
   output logic                         memReqValid,
   input  logic                         memReqReady,
   output logic [fspw_pkg::ADDR_W-1:0]  memReqAddr,
   input  logic                         memRspValid,
   input  logic [fspw_pkg::ADDR_W-1:0]  memRspData,
   // translation result
   output logic                         rspValid,
   input  logic                         rspReady,
   output logic                         rspFault,
   output logic                         rspCanonFault,
   output logic [fspw_pkg::LVL_W-1:0]   rspFaultLevel,
   output logic [fspw_pkg::ADDR_W-1:0]  rspAddr,
   output fspw_pkg::fspw_page_t         rspPageSize,
   output logic [fspw_pkg::PASID_W-1:0] rspPasid
);
   typedef enum logic [1:0] {
      S_IDLE,
      S_ISSUE,
      S_WAIT,
      S_RESP
   } fspw_state_t;

   // bit position where a level's index starts
   function automatic int levelShift(input logic [fspw_pkg::LVL_W-1:0] lvl);
      return fspw_pkg::PAGE_SHIFT + fspw_pkg::IDX_BITS * (int'(lvl) - 1);
   endfunction

   function automatic logic [fspw_pkg::IDX_BITS-1:0] levelIndex(
      input logic [fspw_pkg::ADDR_W-1:0] va,
      input logic [fspw_pkg::LVL_W-1:0]  lvl
   );
      logic [fspw_pkg::ADDR_W-1:0] s;
      s = va >> levelShift(lvl);
      return s[fspw_pkg::IDX_BITS-1:0];
   endfunction

   // table base, index of this level, low three bits zero
   function automatic logic [fspw_pkg::ADDR_W-1:0] entryAddr(
      input logic [fspw_pkg::FRAME_W-1:0] base,
      input logic [fspw_pkg::ADDR_W-1:0]  va,
      input logic [fspw_pkg::LVL_W-1:0]   lvl
   );
      logic [fspw_pkg::ADDR_W-1:0] a;
      a = '0;
      a[fspw_pkg::PAGE_SHIFT +: fspw_pkg::FRAME_W] = base;
      a[fspw_pkg::ENTRY_SHIFT +: fspw_pkg::IDX_BITS] = levelIndex(va, lvl);
      return a;
   endfunction

   // frame bits from the entry, page offset from the input address
   function automatic logic [fspw_pkg::ADDR_W-1:0] mapAddr(
      input logic [fspw_pkg::ADDR_W-1:0] entry,
      input logic [fspw_pkg::ADDR_W-1:0] va,
      input logic [fspw_pkg::LVL_W-1:0]  lvl
   );
      logic [fspw_pkg::ADDR_W-1:0] mask;
      logic [fspw_pkg::ADDR_W-1:0] frame;
      mask  = ({fspw_pkg::ADDR_W{1'b1}} << levelShift(lvl));
      frame = '0;
      frame[fspw_pkg::PAGE_SHIFT +: fspw_pkg::FRAME_W] = entry[fspw_pkg::PA_TOP:fspw_pkg::PAGE_SHIFT];
      return (frame & mask) | (va & ~mask);
   endfunction

   function automatic logic canonical(input logic [fspw_pkg::ADDR_W-1:0] va, input logic five);
      logic [fspw_pkg::ADDR_W-1:0] hi;
      int n;
      n  = five ? fspw_pkg::CANON5_N : fspw_pkg::CANON4_N;
      hi = va >> (n - 1);
      // all ones or all zeros from bit n-1 upward
      return (hi == '0) || ((hi | ({fspw_pkg::ADDR_W{1'b1}} << (fspw_pkg::ADDR_W - n + 1))) == '1);
   endfunction

   function automatic fspw_pkg::fspw_page_t levelPage(input logic [fspw_pkg::LVL_W-1:0] lvl);
      if (lvl == fspw_pkg::LVL_GIANT) begin
         return fspw_pkg::PAGE_1G;
      end else if (lvl == fspw_pkg::LVL_LARGE) begin
         return fspw_pkg::PAGE_2M;
      end
      return fspw_pkg::PAGE_4K;
   endfunction

   fspw_state_t                  state_r, state_nxt;
   logic [fspw_pkg::ADDR_W-1:0]  va_r, va_nxt;
   logic                         five_r, five_nxt;
   logic [fspw_pkg::PASID_W-1:0] pasid_r, pasid_nxt;
   logic [fspw_pkg::LVL_W-1:0]   level_r, level_nxt;
   logic [fspw_pkg::FRAME_W-1:0] base_r, base_nxt;
   logic [fspw_pkg::ADDR_W-1:0]  memAddr_r;
   logic                         rspValid_r, rspValid_nxt;
   logic                         rspFault_r, rspFault_nxt;
   logic                         rspCanon_r, rspCanon_nxt;
   logic [fspw_pkg::LVL_W-1:0]   rspLevel_r, rspLevel_nxt;
   logic [fspw_pkg::ADDR_W-1:0]  rspAddr_r, rspAddr_nxt;
   fspw_pkg::fspw_page_t         rspPage_r, rspPage_nxt;

   fspw_check_if chk ();

   fspw_entry_check u_check (
      .chk (chk)
   );

   wire reqFive   = stageOnePagingMode && fspw_pkg::FIVE_LEVEL_SUPPORT;
   wire [fspw_pkg::LVL_W-1:0] reqTop = reqFive ? fspw_pkg::LVL_ROOT5 : fspw_pkg::LVL_ROOT4;
   wire accept    = reqValid && reqReady;
   // canonical test ahead of any fetch
   wire reqCanon  = canonical(reqAddr, reqFive);
   wire [fspw_pkg::PASID_W-1:0] effPasid = reqHasPasid ? reqPasid : defaultRequestPasid;
   wire entryIn   = (state_r == S_WAIT) && memRspValid;
   wire [fspw_pkg::ADDR_W-1:0] nextAddr = entryAddr(base_nxt, va_nxt, level_nxt);

   assign giantPageSupport = fspw_pkg::GIANT_PAGE_SUPPORT;
   assign chk.entry   = memRspData;
   assign chk.level   = level_r;
   assign chk.host_addr_width     = hostAddrWidth;
   assign chk.noExec  = noExecEnable;
   assign chk.giantOk = fspw_pkg::GIANT_PAGE_SUPPORT;

   assign reqReady      = state_r == S_IDLE;
   assign memReqValid   = state_r == S_ISSUE;
   assign memReqAddr    = memAddr_r;
   assign rspValid      = rspValid_r;
   assign rspFault      = rspFault_r;
   assign rspCanonFault = rspCanon_r;
   assign rspFaultLevel = rspLevel_r;
   assign rspAddr       = rspAddr_r;
   assign rspPageSize   = rspPage_r;
   assign rspPasid      = pasid_r;

   always_comb begin
      state_nxt    = state_r;
      va_nxt       = va_r;
      five_nxt     = five_r;
      pasid_nxt    = pasid_r;
      level_nxt    = level_r;
      base_nxt     = base_r;
      rspValid_nxt = rspValid_r;
      rspFault_nxt = rspFault_r;
      rspCanon_nxt = rspCanon_r;
      rspLevel_nxt = rspLevel_r;
      rspAddr_nxt  = rspAddr_r;
      rspPage_nxt  = rspPage_r;
      case (state_r)
         S_IDLE: begin
            if (accept) begin
               va_nxt    = reqAddr;
               five_nxt  = reqFive;
               pasid_nxt = effPasid;
               level_nxt = reqTop;
               // top table comes from the PASID-table pointer
               base_nxt  = stageOneTablePointer;
               if (!reqCanon) begin
                  state_nxt    = S_RESP;
                  rspValid_nxt = 1'b1;
                  rspFault_nxt = 1'b1;
                  rspCanon_nxt = 1'b1;
                  rspLevel_nxt = fspw_pkg::LVL_NONE;
                  rspAddr_nxt  = '0;
                  rspPage_nxt  = fspw_pkg::PAGE_4K;
               end else begin
                  state_nxt = S_ISSUE;
               end
            end
         end
         S_ISSUE: begin
            if (memReqReady) begin
               state_nxt = S_WAIT;
            end
         end
         S_WAIT: begin
            if (memRspValid) begin
               if (chk.fault) begin
                  // stop without using the faulting entry
                  state_nxt    = S_RESP;
                  rspValid_nxt = 1'b1;
                  rspFault_nxt = 1'b1;
                  rspCanon_nxt = 1'b0;
                  rspLevel_nxt = level_r;
                  rspAddr_nxt  = '0;
                  rspPage_nxt  = fspw_pkg::PAGE_4K;
               end else if (chk.leaf) begin
                  state_nxt    = S_RESP;
                  rspValid_nxt = 1'b1;
                  rspFault_nxt = 1'b0;
                  rspCanon_nxt = 1'b0;
                  rspLevel_nxt = fspw_pkg::LVL_NONE;
                  rspAddr_nxt  = mapAddr(memRspData, va_r, level_r);
                  rspPage_nxt  = levelPage(level_r);
               end else begin
                  state_nxt = S_ISSUE;
                  level_nxt = level_r - fspw_pkg::LVL_LEAF;
                  base_nxt  = memRspData[fspw_pkg::PA_TOP:fspw_pkg::PAGE_SHIFT];
               end
            end
         end
         S_RESP: begin
            if (rspReady) begin
               state_nxt    = S_IDLE;
               rspValid_nxt = 1'b0;
            end
         end
         default: begin
            state_nxt = S_IDLE;
         end
      endcase
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         state_r <= S_IDLE;
         va_r    <= '0;
         five_r  <= 1'b0;
         pasid_r <= '0;
         level_r <= fspw_pkg::LVL_NONE;
         base_r  <= '0;
      end else begin
         state_r <= state_nxt;
         va_r    <= va_nxt;
         five_r  <= five_nxt;
         pasid_r <= pasid_nxt;
         level_r <= level_nxt;
         base_r  <= base_nxt;
      end
   end

   // one aligned read address per level
   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         memAddr_r <= '0;
      end else begin
         memAddr_r <= nextAddr;
      end
   end

   always_ff @(posedge clock or posedge reset) begin
      if (reset) begin
         rspValid_r <= 1'b0;
         rspFault_r <= 1'b0;
         rspCanon_r <= 1'b0;
         rspLevel_r <= fspw_pkg::LVL_NONE;
         rspAddr_r  <= '0;
         rspPage_r  <= fspw_pkg::PAGE_4K;
      end else begin
         rspValid_r <= rspValid_nxt;
         rspFault_r <= rspFault_nxt;
         rspCanon_r <= rspCanon_nxt;
         rspLevel_r <= rspLevel_nxt;
         rspAddr_r  <= rspAddr_nxt;
         rspPage_r  <= rspPage_nxt;
      end
   end

   a_pasid_default: assert property (@(posedge clock) disable iff (reset)
      accept && !reqHasPasid |=> pasid_r == $past(defaultRequestPasid))
      else $error("untagged request did not take the default PASID");

   a_canon_fault: assert property (@(posedge clock) disable iff (reset)
      accept && !reqCanon |=> rspValid && rspFault && rspCanonFault && !memReqValid)
      else $error("non-canonical address was not faulted at once");

   a_walk_depth: assert property (@(posedge clock) disable iff (reset)
      accept && reqCanon |=> memReqValid && !rspValid
         && (level_r == ($past(stageOnePagingMode) ? fspw_pkg::LVL_ROOT5 : fspw_pkg::LVL_ROOT4)))
      else $error("walk started at the wrong level");

   a_index_l5: assert property (@(posedge clock) disable iff (reset)
      memReqValid && level_r == fspw_pkg::LVL_ROOT5 |-> memReqAddr[11:3] == va_r[56:48]
         && memReqAddr[2:0] == 3'h0)
      else $error("level-5 entry address wrong");

   a_index_l4: assert property (@(posedge clock) disable iff (reset)
      memReqValid && level_r == fspw_pkg::LVL_ROOT4 |-> memReqAddr[11:3] == va_r[47:39])
      else $error("level-4 entry address wrong");

   a_index_l3: assert property (@(posedge clock) disable iff (reset)
      memReqValid && level_r == fspw_pkg::LVL_GIANT |-> memReqAddr[11:3] == va_r[38:30])
      else $error("level-3 entry address wrong");

   a_index_l2: assert property (@(posedge clock) disable iff (reset)
      memReqValid && level_r == fspw_pkg::LVL_LARGE |-> memReqAddr[11:3] == va_r[29:21])
      else $error("level-2 entry address wrong");

   a_index_leaf: assert property (@(posedge clock) disable iff (reset)
      memReqValid && level_r == fspw_pkg::LVL_LEAF |-> memReqAddr[11:3] == va_r[20:12])
      else $error("leaf entry address wrong");

   a_giant_offset: assert property (@(posedge clock) disable iff (reset)
      rspValid && !rspFault && rspPageSize == fspw_pkg::PAGE_1G |-> rspAddr[29:0] == va_r[29:0])
      else $error("1-GByte offset not from input address");

   a_large_offset: assert property (@(posedge clock) disable iff (reset)
      rspValid && !rspFault && rspPageSize == fspw_pkg::PAGE_2M |-> rspAddr[20:0] == va_r[20:0])
      else $error("2-MByte offset not from input address");

   a_leaf_frame: assert property (@(posedge clock) disable iff (reset)
      entryIn && level_r == fspw_pkg::LVL_LEAF && !chk.fault |=> rspValid && !rspFault
         && rspPageSize == fspw_pkg::PAGE_4K && rspAddr[51:12] == $past(memRspData[51:12])
         && rspAddr[11:0] == va_r[11:0])
      else $error("leaf mapping formed wrongly");

   a_absent_fault: assert property (@(posedge clock) disable iff (reset)
      entryIn && !memRspData[0] |=> rspValid && rspFault && rspFaultLevel == $past(level_r))
      else $error("absent entry did not fault");

   a_top_ps_rsv: assert property (@(posedge clock) disable iff (reset)
      entryIn && level_r >= fspw_pkg::LVL_ROOT4 && memRspData[7] |=> rspFault)
      else $error("page size in top levels did not fault");

   a_xd_rsv: assert property (@(posedge clock) disable iff (reset)
      entryIn && !noExecEnable && memRspData[63] |=> rspValid && rspFault)
      else $error("execute-disable bit not reserved");

   a_one_read: assert property (@(posedge clock) disable iff (reset)
      memReqValid && memReqReady |=> !memReqValid ##0 (state_r == S_WAIT) [*1])
      else $error("more than one read outstanding");

   a_resp_hold: assert property (@(posedge clock) disable iff (reset)
      rspValid && !rspReady |=> rspValid && $stable(rspAddr) && $stable(rspFault))
      else $error("result dropped before it was taken");
endmodule

// ===== fspw_mem_model.sv
// behavioural memory holding the paging-structure tables
`timescale 1ns/1ps
module fspw_mem_model (
   // clock and reset
   input  logic                        clock,
   input  logic                        reset,
   // entry read port
   input  logic                        memReqValid,
   output logic                        memReqReady,
   input  logic [fspw_pkg::ADDR_W-1:0] memReqAddr,
   output logic                        memRspValid,
   output logic [fspw_pkg::ADDR_W-1:0] memRspData
);
   logic [63:0] tbl [logic [63:0]];
   logic [63:0] heldData;
   logic        busy;
   int          waitCnt;
   bit          slowMode = 1'b0;
   // unknown addresses read as zero, so a wrong entry address shows up as an absent entry
   always @(posedge clock or posedge reset) begin
      if (reset) begin
         busy        <= 1'b0;
         memRspValid <= 1'b0;
         memReqReady <= 1'b0;
         memRspData  <= 64'h0;
      end else begin
         memRspValid <= 1'b0;
         // data lines alternate between the last entry and its complement outside the response cycle
         memRspData  <= ~memRspData;
         if (busy && waitCnt == 0) begin
            busy        <= 1'b0;
            memRspValid <= 1'b1;
            memRspData  <= heldData;
         end else if (busy) begin
            waitCnt <= waitCnt - 1;
         end else if (memReqValid && memReqReady) begin
            busy        <= 1'b1;
            memReqReady <= 1'b0;
            waitCnt     <= slowMode ? $urandom_range(3) : 0;
            heldData    <= tbl.exists(memReqAddr) ? tbl[memReqAddr] : 64'h0;
         end else begin
            memReqReady <= slowMode ? 1'($urandom_range(1)) : 1'b1;
         end
      end
   end
endmodule

// ===== first_stage_page_walker_bench.sv
// self-checking bench for the first-stage page walker
`timescale 1ns/1ps
module first_stage_page_walker_bench;
   typedef struct {
      logic        f;
      logic        c;
      logic [2:0]  l;
      logic [63:0] a;
      logic [1:0]  s;
      logic [19:0] p;
   } fspw_exp_t;
   logic                 clock = 1'b0;
   logic                 reset = 1'b1;
   logic                 reqValid = 1'b0, reqReady, reqHasPasid = 1'b0, stageOnePagingMode = 1'b0;
   logic [63:0]          reqAddr = 64'h0, memReqAddr, memRspData, rspAddr;
   logic [19:0]          reqPasid = 20'h0, defaultRequestPasid = 20'h0, rspPasid;
   logic [39:0]          stageOneTablePointer = 40'h0;
   logic                 noExecEnable = 1'b1, giantPageSupport, memReqValid, memReqReady, memRspValid;
   logic [5:0]           hostAddrWidth = 6'h34;
   logic                 rspValid, rspReady = 1'b0, rspFault, rspCanonFault;
   logic [2:0]           rspFaultLevel;
   fspw_pkg::fspw_page_t rspPageSize;
   fspw_exp_t            expQ[$];
   fspw_exp_t            got;
   int                   numErrors = 0, cmpCount = 0, n = 0, host_addr_width = 44;

   always #4 clock = ~clock;

   first_stage_page_walker uut (.clock(clock), .reset(reset), .reqValid(reqValid), .reqReady(reqReady),
      .reqAddr(reqAddr), .reqHasPasid(reqHasPasid), .reqPasid(reqPasid),
      .defaultRequestPasid(defaultRequestPasid), .stageOnePagingMode(stageOnePagingMode),
      .stageOneTablePointer(stageOneTablePointer), .noExecEnable(noExecEnable),
      .hostAddrWidth(hostAddrWidth), .giantPageSupport(giantPageSupport), .memReqValid(memReqValid),
      .memReqReady(memReqReady), .memReqAddr(memReqAddr), .memRspValid(memRspValid),
      .memRspData(memRspData), .rspValid(rspValid), .rspReady(rspReady), .rspFault(rspFault),
      .rspCanonFault(rspCanonFault), .rspFaultLevel(rspFaultLevel), .rspAddr(rspAddr),
      .rspPageSize(rspPageSize), .rspPasid(rspPasid));

   fspw_mem_model mem (.clock(clock), .reset(reset), .memReqValid(memReqValid), .memReqReady(memReqReady),
      .memReqAddr(memReqAddr), .memRspValid(memRspValid), .memRspData(memRspData));

   task automatic cmp(input string what, input logic [63:0] exp, input logic [63:0] seen);
      cmpCount++;
      if (seen !== exp) begin
         numErrors++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic summarize();
      $display("comparisons %0d mismatches %0d", cmpCount, numErrors);
      if (numErrors == 0 && cmpCount > 0) begin
         $display("RESULT: PASS");
      end else begin
         $display("RESULT: FAIL");
      end
      $finish;
   endtask

   // addresses keep only the bits below w, the sign bit of the chosen canonical width
   function automatic logic [63:0] rv(input int w);
      return {$urandom, $urandom} & ((64'h1 << w) - 64'h1);
   endfunction

   // builds the table chain for va, then issues it; bl names the entry spoiled by bad (zero: absent)
   task automatic run(input logic [63:0] va, input logic m5, input int ps, input int bl,
                      input logic [63:0] bad, input logic flt, input logic nx);
      logic [39:0] fr;
      logic [39:0] nxt;
      logic [63:0] e;
      logic [63:0] idx;
      logic        hp;
      logic [19:0] rp;
      logic [19:0] dp;
      fspw_exp_t   x;
      int          l;
      n++;
      fr = 40'(n) << 8;
      mem.slowMode = n[0];
      l = m5 ? 5 : 4;
      while (l > 0) begin
         idx = (va >> (3 + 9 * l)) & 64'h1FF;
         nxt = (l == ps || l == 1) ? 40'hABC00000 : fr + 40'h1;
         e = {12'h0, nxt, 12'h1} | ((l == ps) ? 64'h80 : 64'h0);
         if (l == bl) e = (bad == 64'h0) ? 64'h0 : e | bad;
         mem.tbl[{12'h0, fr, 12'h0} | (idx << 3)] = e;
         l = (l == ps) ? 0 : l - 1;
         fr = nxt;
      end
      hp = 1'($urandom_range(1));
      rp = 20'($urandom);
      dp = 20'($urandom);
      x.f = flt;
      x.c = flt && bl == 0;
      x.l = flt ? 3'(bl) : 3'h0;
      x.s = flt ? 2'h0 : (ps == 3 ? 2'h2 : (ps == 2 ? 2'h1 : 2'h0));
      x.a = flt ? 64'h0 : 64'h0000_0ABC_0000_0000 | (va & ((64'h1 << (ps == 3 ? 30 : (ps == 2 ? 21 : 12))) - 64'h1));
      x.p = hp ? rp : dp;
      // the no-execute input is read live, so it only changes between walks
      for (int w = 0; w < 2000 && expQ.size() != 0 && nx !== noExecEnable; w++) @(posedge clock);
      @(posedge clock);
      reqValid             <= 1'b1;
      reqAddr              <= va;
      reqHasPasid          <= hp;
      reqPasid             <= rp;
      defaultRequestPasid  <= dp;
      stageOnePagingMode   <= m5;
      stageOneTablePointer <= 40'(n) << 8;
      noExecEnable         <= nx;
      @(posedge clock);
      for (int w = 0; w < 2000 && reqReady !== 1'b1; w++) @(posedge clock);
      expQ.push_back(x);
      reqValid <= 1'b0;
   endtask

   always @(posedge clock) rspReady <= 1'($urandom_range(1));

   always @(posedge clock) begin
      if (!reset && rspValid === 1'b1 && rspReady === 1'b1) begin
         cmp("pending", 64'h1, 64'(expQ.size() != 0));
         got = expQ.pop_front();
         cmp("fault", 64'(got.f), 64'(rspFault));
         cmp("canon", 64'(got.c), 64'(rspCanonFault));
         cmp("level", 64'(got.l), 64'(rspFaultLevel));
         cmp("addr", got.a, rspAddr);
         cmp("size", 64'(got.s), 64'(rspPageSize));
         cmp("pasid", 64'(got.p), 64'(rspPasid));
      end
   end

   initial begin
      repeat (30000) @(posedge clock);
      numErrors++;
      summarize();
   end

   initial begin
      int m;
      void'($urandom(15));
      repeat (20) @(posedge clock);
      reset <= 1'b0;
      host_addr_width = 44 + $urandom_range(7);
      hostAddrWidth <= 6'(host_addr_width);
      @(posedge clock);
      cmp("giant", 64'h1, 64'(giantPageSupport));
      run(rv(47), 0, 0, 0, 64'h0, 1'b0, 1'b1);
      run(rv(56), 1, 2, 0, 64'h0, 1'b0, 1'b1);
      run(rv(47), 0, 3, 0, 64'h0, 1'b0, 1'b1);
      run(rv(47) | 64'h0004_0000_0000_0000, 0, 0, 0, 64'h0, 1'b1, 1'b1);
      run(rv(56) | 64'h1000_0000_0000_0000, 1, 0, 0, 64'h0, 1'b1, 1'b1);
      run(rv(47) | 64'h0000_8000_0000_0000, 0, 0, 0, 64'h0, 1'b1, 1'b1);
      run(rv(47) | 64'h0000_8000_0000_0000, 1, 0, 0, 64'h0, 1'b0, 1'b1);
      run(rv(47), 0, 0, 3, 64'h0, 1'b1, 1'b1);
      run(rv(56), 1, 0, 5, 64'h0, 1'b1, 1'b1);
      run(rv(47), 0, 0, 2, 64'h1 << host_addr_width, 1'b1, 1'b1);
      run(rv(47), 0, 0, 1, 64'h0008_0000_0000_0000, 1'b1, 1'b1);
      run(rv(56), 1, 0, 5, 64'h80, 1'b1, 1'b1);
      run(rv(47), 0, 0, 4, 64'h80, 1'b1, 1'b1);
      run(rv(47), 0, 2, 2, 64'h2000, 1'b1, 1'b1);
      run(rv(47), 0, 2, 2, 64'h10_0000, 1'b1, 1'b1);
      run(rv(47), 0, 3, 3, 64'h2000_0000, 1'b1, 1'b1);
      run(rv(47), 0, 0, 1, 64'h400, 1'b0, 1'b1);
      run(rv(47), 0, 0, 2, 64'h8000_0000_0000_0000, 1'b1, 1'b0);
      run(rv(47), 0, 0, 2, 64'h8000_0000_0000_0000, 1'b0, 1'b1);
      for (int i = 0; i < 16; i++) begin
         m = $urandom_range(1);
         run(rv(m ? 56 : 47), m, $urandom_range(3), 0, 64'h0, 1'b0, 1'b1);
      end
      for (int w = 0; w < 2000 && expQ.size() != 0; w++) @(posedge clock);
      cmp("drained", 64'h0, 64'(expQ.size()));
      summarize();
   end
endmodule
